// file: src/ldi_top.sv
// Purpose: write-only two-wire slave and register file of an led driver
// Assumes: bus clock and pins are asynchronous and sampled here
// Notes:   data line is open drain; sda_oe_out high pulls it low
`timescale 1ns/100ps
`include "ldi_cfg.svh"
// What this block does
// - Answer address 01111 plus two select bits, then direction bit.
// - Select pin: ground 00, supply 11, clock line 01, data line 10.
// - Only writes; direction bit must be 0, nothing reads back.
// - Data line sampled while clock line is high.
// - Data falling with clock high starts address comparison.
// - Matching address is acknowledged by holding data low on ninth pulse.
// - Second byte loads the register pointer and is acknowledged.
// - Each data byte is written at the pointer and acknowledged.
// - Data rising with clock high ends the transfer.
// - Pointer advances by one during each data acknowledge.
// - Offset 00h bit 0: 0 shutdown, 1 normal run.
// - Offsets 01h to 24h hold 36 eight-bit duty values.
// - Channel average equals scaled current times duty over 256.
// - Write of 00h to offset 25h copies pending settings to active ones.
// - Offsets 26h to 49h hold channel enable and current scale.
// - Write to offset 4Fh returns all registers to defaults.
// - Shutdown, duty and global registers reset to zero.
// - Duty and control writes wait in shadow until update key written.
// - Control bit 0 enables channel; bits 2:1 select current scale.
// - Offset 4Ah bit 0 set switches every channel off.
// - Hardware shutdown pin low shuts down regardless of registers.
module ldi_top
  import ldi_pkg::*;
#(
  parameter int NCH = `LDI_NCH
) (
  // clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  // two-wire bus and straps
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_out,
  input  wire logic                addr_sel_in,
  input  wire logic                hard_shutdown_pin_n_in,
  // channel outputs
  output logic [NCH-1:0]           chan_drive_out,
  output logic [NCH-1:0][1:0]      current_scale_sel_out,
  output logic                     active_out
);
  localparam int IDXW = $clog2(NCH);
  ldi_top_st_t                st;
  ldi_top_st_t                next_st;
  logic [`LDI_PIN_N-1:0]      pin_s;
  logic                       scl_s;
  logic                       sda_s;
  logic                       ad_s;
  logic                       hsd_n_s;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_det;
  logic                       stop_det;
  logic [1:0]                 ad_sel;
  logic                       addr_match;
  logic                       wr_en;
  logic [7:0]                 wr_idx;
  logic [IDXW-1:0]            duty_idx;
  logic [IDXW-1:0]            ctl_idx;

  ldi_chan_if #(.NCH(NCH)) chan ();

  ldi_pin_sync #(.W(`LDI_PIN_N)) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    ({hard_shutdown_pin_n_in, addr_sel_in, sda_in, scl_in}),
    .sync_out    (pin_s)
  );

  assign scl_s     = pin_s[0];
  assign sda_s     = pin_s[1];
  assign ad_s      = pin_s[2];
  assign hsd_n_s   = pin_s[3];
  assign scl_rise  = scl_s & ~st.scl_q;
  assign scl_fall  = ~scl_s & st.scl_q;
  assign start_det = scl_s & st.scl_q & st.sda_q & ~sda_s;
  assign stop_det  = scl_s & st.scl_q & ~st.sda_q & sda_s;

  // strap decode from three samples of the select pin
  always_comb begin
    if (!st.ad_idle) begin
      ad_sel = `LDI_AD_GND;
    end else if (!st.ad_start) begin
      ad_sel = `LDI_AD_SDA;
    end else if (!st.ad_low) begin
      ad_sel = `LDI_AD_SCL;
    end else begin
      ad_sel = `LDI_AD_VCC;
    end
  end

  assign addr_match = (st.shreg[7:3] == `LDI_SLV_HI) &&
                      (st.shreg[2:1] == ad_sel) &&
                      (st.shreg[0] == `LDI_RW_WRITE);
  assign wr_en  = (st.state == S_DATA) && st.full && scl_fall;
  assign wr_idx = st.ptr;
  // shadow slot picked by the pointer, cut to the bank index width
  assign duty_idx = IDXW'(wr_idx - `LDI_OFF_DUTY0);
  assign ctl_idx  = IDXW'(wr_idx - `LDI_OFF_CTL0);

  always_comb begin
    next_st       = st;
    next_st.scl_q = scl_s;
    next_st.sda_q = sda_s;
    if (st.state == S_IDLE && scl_s && sda_s) begin
      next_st.ad_idle = ad_s;
    end
    if (start_det) begin
      next_st.state    = S_ADDR;
      next_st.bitc     = 3'h0;
      next_st.full     = 1'b0;
      next_st.sda_oe   = 1'b0;
      next_st.ad_start = ad_s;
      next_st.ad_taken = 1'b0;
    end else if (stop_det) begin
      next_st.state  = S_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      case (st.state)
        S_ADDR, S_PTR, S_DATA: begin
          if (scl_fall && !st.ad_taken && st.state == S_ADDR) begin
            next_st.ad_low   = ad_s;
            next_st.ad_taken = 1'b1;
          end
          if (scl_rise && !st.full) begin
            next_st.shreg = {st.shreg[6:0], sda_s};
            next_st.bitc  = st.bitc + 3'h1;
            next_st.full  = (st.bitc == `LDI_BIT_LAST);
          end else if (scl_fall && st.full) begin
            next_st.full = 1'b0;
            if (st.state == S_ADDR) begin
              next_st.state  = addr_match ? S_AACK : S_IGN;
              next_st.sda_oe = addr_match;
            end else if (st.state == S_PTR) begin
              next_st.ptr    = st.shreg;
              next_st.state  = S_PACK;
              next_st.sda_oe = 1'b1;
            end else begin
              next_st.ptr    = st.ptr + 8'h01;
              next_st.state  = S_DACK;
              next_st.sda_oe = 1'b1;
            end
          end
        end
        S_AACK, S_PACK, S_DACK: begin
          if (scl_fall) begin
            next_st.sda_oe = 1'b0;
            next_st.state  = (st.state == S_AACK) ? S_PTR : S_DATA;
          end
        end
        S_IDLE, S_IGN: begin
          next_st.sda_oe = 1'b0;
        end
        default: begin
          next_st.state  = S_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end

    if (wr_en) begin
      if (wr_idx == `LDI_OFF_SSD) begin
        next_st.soft_run = st.shreg[0];
      end else if (wr_idx >= `LDI_OFF_DUTY0 &&
                   wr_idx <= `LDI_OFF_DUTYN) begin
        next_st.duty_sh[duty_idx] = st.shreg;
      end else if (wr_idx == `LDI_OFF_UPD) begin
        if (st.shreg == `LDI_UPD_KEY) begin
          next_st.duty_act = st.duty_sh;
          next_st.ctl_act  = st.ctl_sh;
        end
      end else if (wr_idx >= `LDI_OFF_CTL0 &&
                   wr_idx <= `LDI_OFF_CTLN) begin
        next_st.ctl_sh[ctl_idx] = st.shreg[2:0];
      end else if (wr_idx == `LDI_OFF_GDIS) begin
        next_st.gdis = st.shreg[0];
      end else if (wr_idx == `LDI_OFF_RST) begin
        next_st.soft_run = `LDI_RST_BIT;
        next_st.gdis     = `LDI_RST_BIT;
        next_st.duty_sh  = '0;
        next_st.duty_act = '0;
        next_st.ctl_sh   = '0;
        next_st.ctl_act  = '0;
      end
      // any other offset is acknowledged and dropped
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st          <= '0;
      st.state    <= S_IDLE;
      st.scl_q    <= 1'b1;
      st.sda_q    <= 1'b1;
      st.ad_idle  <= 1'b1;
      st.ad_start <= 1'b1;
      st.ad_low   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign chan.duty[g]             = st.duty_act[g];
      assign chan.en[g]               = st.ctl_act[g][`LDI_CTL_EN];
      assign current_scale_sel_out[g] = st.ctl_act[g][2:1];
    end
  endgenerate
  assign chan.run = st.soft_run & ~st.gdis & hsd_n_s;

  ldi_pwm #(.NCH(NCH)) u_pwm (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .cfg         (chan),
    .chan_out    (chan_drive_out),
    .active_out  (active_out)
  );

  assign sda_out    = 1'b0;
  assign sda_oe_out = st.sda_oe;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_upd_write;
    wr_en && wr_idx == `LDI_OFF_UPD && st.shreg == `LDI_UPD_KEY;
  endsequence
  sequence s_rst_write;
    wr_en && wr_idx == `LDI_OFF_RST;
  endsequence

  a_addr_ack_held: assert property (
    (st.state == S_ADDR && st.full && scl_fall && addr_match && !start_det
     && !stop_det) |=> sda_oe_out && st.state == S_AACK)
    else $error("matching address not acknowledged");
  a_addr_nack: assert property (
    (st.state == S_ADDR && st.full && scl_fall && !addr_match && !start_det
     && !stop_det) |=> !sda_oe_out [*2])
    else $error("foreign address acknowledged");
  a_ptr_step: assert property (wr_en && !start_det && !stop_det
    |=> st.ptr == $past(st.ptr) + 8'h01)
    else $error("pointer did not advance");
  a_update_copy: assert property (s_upd_write |=>
    st.duty_act == $past(st.duty_sh) && st.ctl_act == $past(st.ctl_sh))
    else $error("update did not copy shadow");
  a_shadow_hold: assert property (
    !(wr_en && wr_idx == `LDI_OFF_UPD && st.shreg == `LDI_UPD_KEY) &&
    !(wr_en && wr_idx == `LDI_OFF_RST) |=> $stable(st.duty_act))
    else $error("active duty changed without update");
  a_soft_reset: assert property (s_rst_write |=>
    !st.soft_run && st.duty_act == '0 && st.ctl_sh == '0)
    else $error("soft reset left state");
  a_start_addr: assert property (start_det |=> st.state == S_ADDR)
    else $error("start not followed by address phase");
  a_stop_idle: assert property (stop_det && !start_det
    |=> st.state == S_IDLE && !sda_oe_out)
    else $error("stop did not end transfer");
  a_ssd_write: assert property (wr_en && wr_idx == `LDI_OFF_SSD
    |=> st.soft_run == $past(st.shreg[0]))
    else $error("shutdown bit not written");
  a_unmapped_nop: assert property (wr_en && wr_idx == `LDI_OFF_FREE0
    |=> $stable(st.duty_sh) && $stable(st.ctl_sh) && $stable(st.soft_run))
    else $error("unassigned offset changed state");
  a_ack_release: assert property (
    (st.state == S_AACK && scl_fall && !start_det && !stop_det)
    |=> !sda_oe_out && st.state == S_PTR)
    else $error("address acknowledge not released");
  a_ptr_load: assert property (
    (st.state == S_PTR && st.full && scl_fall)
    |=> st.ptr == $past(st.shreg) && sda_oe_out)
    else $error("pointer byte not loaded");
  a_data_ack: assert property (
    wr_en |=> sda_oe_out && st.state == S_DACK)
    else $error("data byte not acknowledged");
  a_duty_shadow: assert property (
    wr_en && wr_idx >= `LDI_OFF_DUTY0 && wr_idx <= `LDI_OFF_DUTYN
    |=> st.duty_sh[$past(duty_idx)] == $past(st.shreg))
    else $error("duty byte not stored");
  a_ctl_shadow: assert property (
    wr_en && wr_idx >= `LDI_OFF_CTL0 && wr_idx <= `LDI_OFF_CTLN
    |=> st.ctl_sh[$past(ctl_idx)] == $past(st.shreg[2:0]))
    else $error("control byte not stored");
  a_gdis_write: assert property (
    wr_en && wr_idx == `LDI_OFF_GDIS |=> st.gdis == $past(st.shreg[0]))
    else $error("global disable not written");
  a_scale_out: assert property (
    s_upd_write |=> current_scale_sel_out[0] == $past(st.ctl_sh[0][2:1]))
    else $error("scale output not taken from update");
  a_hard_off: assert property (
    !hsd_n_s |=> !active_out && chan_drive_out == '0)
    else $error("outputs on while shutdown pin low");
endmodule

// file: src/ldi_cfg.svh
// Purpose: constants of the led driver write slave
// Assumes: included by bare name from the package and modules
// Notes:   offsets are byte values of the register pointer
`ifndef LDI_CFG_SVH
`define LDI_CFG_SVH

`define LDI_NCH        36
`define LDI_DW         8
`define LDI_SLV_HI     5'h0F
`define LDI_RW_WRITE   1'h0
`define LDI_AD_GND     2'h0
`define LDI_AD_SCL     2'h1
`define LDI_AD_SDA     2'h2
`define LDI_AD_VCC     2'h3
`define LDI_BIT_LAST   3'h7
`define LDI_OFF_SSD    8'h00
`define LDI_OFF_DUTY0  8'h01
`define LDI_OFF_DUTYN  8'h24
`define LDI_OFF_UPD    8'h25
`define LDI_OFF_CTL0   8'h26
`define LDI_OFF_CTLN   8'h49
`define LDI_OFF_GDIS   8'h4A
`define LDI_OFF_FREE0  8'h4B
`define LDI_OFF_RST    8'h4F
`define LDI_UPD_KEY    8'h00
`define LDI_RST_DUTY   8'h00
`define LDI_RST_CTL    3'h0
`define LDI_RST_BIT    1'h0
`define LDI_CTL_EN     0
`define LDI_PIN_N      4

`endif

// file: src/ldi_pkg.sv
// Purpose: shared types of the led driver write slave
// Assumes: ldi_cfg.svh on the include path
// Notes:   top state is one packed struct
`include "ldi_cfg.svh"
package ldi_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_PTR, S_PACK, S_DATA, S_DACK, S_IGN
  } ldi_state_t;

  typedef logic [`LDI_NCH-1:0][`LDI_DW-1:0] ldi_duty_arr_t;
  typedef logic [`LDI_NCH-1:0][2:0]         ldi_ctl_arr_t;

  typedef struct packed {
    ldi_state_t    state;
    logic [2:0]    bitc;
    logic          full;
    logic [7:0]    shreg;
    logic [7:0]    ptr;
    logic          sda_oe;
    logic          scl_q;
    logic          sda_q;
    logic          ad_idle;
    logic          ad_start;
    logic          ad_low;
    logic          ad_taken;
    logic          soft_run;
    logic          gdis;
    ldi_duty_arr_t duty_sh;
    ldi_duty_arr_t duty_act;
    ldi_ctl_arr_t  ctl_sh;
    ldi_ctl_arr_t  ctl_act;
  } ldi_top_st_t;

  typedef struct packed {
    logic [7:0]          cnt;
    logic [`LDI_NCH-1:0] chan;
    logic                on;
  } ldi_pwm_st_t;

endpackage

// file: src/ldi_chan_if.sv
// Purpose: active channel settings from register file to modulator
// Assumes: single clock domain
// Notes:   run already folds in every shutdown source
`timescale 1ns/100ps
interface ldi_chan_if #(parameter int NCH = 36);
  logic [NCH-1:0][7:0] duty;
  logic [NCH-1:0]      en;
  logic                run;
  modport src (output duty, output en, output run);
  modport dst (input duty, input en, input run);
endinterface

// file: src/ldi_pin_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk_in
// Notes:   only sync_out may be read by other logic
`timescale 1ns/100ps
module ldi_pin_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // pins
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ldi_sync_st_t;

  ldi_sync_st_t st;
  ldi_sync_st_t next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = async_in;
    next_st.sync = st.meta;
  end

  // idle bus lines rest high
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.sync;
endmodule

// file: src/ldi_pwm.sv
// Purpose: 256-count modulator for all channels
// Assumes: settings come from the active register bank
// Notes:   duty 255 gives 255 of 256 counts on
`timescale 1ns/100ps
`include "ldi_cfg.svh"
module ldi_pwm
  import ldi_pkg::*;
#(
  parameter int NCH = `LDI_NCH
) (
  // clock and reset
  input  wire logic           core_clk_in,
  input  wire logic           rst_in,
  // settings
  ldi_chan_if.dst             cfg,
  // outputs
  output logic      [NCH-1:0] chan_out,
  output logic                active_out
);
  ldi_pwm_st_t    st;
  ldi_pwm_st_t    next_st;
  logic [NCH-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign hit[g] = cfg.run & cfg.en[g] & (st.cnt < cfg.duty[g]);
    end
  endgenerate

  always_comb begin
    next_st      = st;
    next_st.cnt  = st.cnt + 8'h01;
    next_st.chan = hit;
    next_st.on   = cfg.run;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign chan_out   = st.chan;
  assign active_out = st.on;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_pwm_zero_off: assert property (!cfg.run |=> st.chan == '0)
    else $error("channel on while shut down");
  a_pwm_count_on: assert property (
    (cfg.run && cfg.en[0] && cfg.duty[0] == 8'h00) |=> !st.chan[0])
    else $error("zero duty channel driven");
endmodule

// file: dv/ldi_i2c_master.sv
// Purpose: two-wire bus master model for the led driver slave
// Assumes: data line is resolved outside with a pull-up
// Notes:   clock stands still high between frames
`timescale 1ns/100ps
module ldi_i2c_master (
  // bus
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in,
  // pacing
  input  wire logic slow_in
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // low phase before a rising clock, stretched when slow
  task automatic low_wait();
    #16;
    if (slow_in) begin
      #48;
    end
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    low_wait();
    scl_out = 1'b1;
    #32;
    sda_low_out = 1'b1;
    #32;
    scl_out = 1'b0;
    #16;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    low_wait();
    scl_out = 1'b1;
    #32;
    sda_low_out = 1'b0;
    #64;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = ~b[i];
      low_wait();
      scl_out = 1'b1;
      #32;
      scl_out = 1'b0;
      #16;
    end
    sda_low_out = 1'b0;
    low_wait();
    scl_out = 1'b1;
    #16;
    ack = (sda_in === 1'b0);
    #16;
    scl_out = 1'b0;
    // slave releases late after the ninth fall
    #48;
  endtask
endmodule

// file: dv/ldi_top_tb_top.sv
// Purpose: self-checking bench of the led driver write slave
// Assumes: bus master model drives the pins
// Notes:   random settings from a fixed xorshift seed
`timescale 1ns/100ps
`include "ldi_cfg.svh"
module ldi_top_tb_top;
  import ldi_pkg::*;
  localparam int NCH = `LDI_NCH;
  logic                  core_clk_in;
  logic                  rst_in;
  logic                  scl;
  logic                  sda_low;
  logic                  sda_wire;
  logic                  sda_out;
  logic                  sda_oe_out;
  logic                  addr_sel;
  logic                  pin_n;
  logic                  slow;
  logic [1:0]            mode;
  logic [NCH-1:0]        chan;
  logic [NCH-1:0][1:0]   scale;
  logic                  active;
  logic [31:0]           seed;
  logic [7:0]            duty [4];
  logic [7:0]            ctl [4];
  int                    cnt [4];
  int                    err_count;
  int                    check_count;
  int                    cyc;

  assign sda_wire = ~(sda_low | (sda_oe_out & ~sda_out));
  // strap: 0 ground, 1 clock line, 2 data line, 3 supply
  always_comb begin
    case (mode)
      2'h0: addr_sel = 1'b0;
      2'h1: addr_sel = scl;
      2'h2: addr_sel = sda_wire;
      default: addr_sel = 1'b1;
    endcase
  end

  ldi_i2c_master ldi_i2c_master_inst (
    .scl_out     (scl),
    .sda_low_out (sda_low),
    .sda_in      (sda_wire),
    .slow_in     (slow)
  );
  ldi_top #(.NCH(NCH)) ldi_top_inst (
    .core_clk_in            (core_clk_in),
    .rst_in                 (rst_in),
    .scl_in                 (scl),
    .sda_in                 (sda_wire),
    .sda_out                (sda_out),
    .sda_oe_out             (sda_oe_out),
    .addr_sel_in            (addr_sel),
    .hard_shutdown_pin_n_in (pin_n),
    .chan_drive_out         (chan),
    .current_scale_sel_out  (scale),
    .active_out             (active)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int exp_on(input logic [7:0] d, input logic [7:0] c);
    return c[0] ? int'(d) : 0;
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic do_reset();
    @(negedge core_clk_in);
    rst_in = 1'b1;
    repeat (5) @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (8) @(negedge core_clk_in);
  endtask
  task automatic probe(input logic [7:0] a, input logic exp);
    logic ack;
    ldi_i2c_master_inst.start();
    ldi_i2c_master_inst.send_byte(a, ack);
    if (ack !== exp) chk(1'b0, "address answer wrong");
    else chk(1'b1, "");
    ldi_i2c_master_inst.stop();
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic ack;
    ldi_i2c_master_inst.start();
    ldi_i2c_master_inst.send_byte({`LDI_SLV_HI, mode, `LDI_RW_WRITE}, ack);
    chk(ack === 1'b1, "address not acknowledged");
    ldi_i2c_master_inst.send_byte(ptr, ack);
    chk(ack === 1'b1, "pointer not acknowledged");
    foreach (d[i]) begin
      ldi_i2c_master_inst.send_byte(d[i], ack);
      chk(ack === 1'b1, "data not acknowledged");
    end
    ldi_i2c_master_inst.stop();
    repeat (8) @(negedge core_clk_in);
  endtask
  task automatic verify(input logic upd);
    cnt = '{0, 0, 0, 0};
    repeat (256) begin
      @(negedge core_clk_in);
      // an unknown level must spoil the count, not read as off
      for (int i = 0; i < 4; i++) begin
        cnt[i] += (chan[i] === 1'b1) ? 1 : (chan[i] === 1'b0) ? 0 : 512;
      end
    end
    for (int i = 0; i < 4; i++) begin
      chk(scale[i] === (upd ? ctl[i][2:1] : 2'h0), "scale");
      chk(cnt[i] == (upd ? exp_on(duty[i], ctl[i]) : 0), "duty");
    end
  endtask

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      $display("MISMATCH %0t run did not finish", $time);
      test_done();
    end
  end

  initial begin
    rst_in = 1'b1;
    pin_n = 1'b1;
    slow = 1'b0;
    mode = 2'h0;
    seed = 32'd25;
    repeat (5) @(negedge core_clk_in);
    rst_in = 1'b0;
    for (int md = 0; md < 4; md++) begin
      mode = md[1:0];
      do_reset();
      probe({`LDI_SLV_HI, mode, 1'b0}, 1'b1);
      probe({5'h1F, mode, 1'b0}, 1'b0);
      probe({`LDI_SLV_HI, mode ^ 2'h1, 1'b0}, 1'b0);
      probe({`LDI_SLV_HI, mode, 1'b1}, 1'b0);
    end
    chk(active === 1'b0 && chan === '0, "not idle after reset");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      duty[i] = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
      ctl[i] = {5'h00, seed[10:9], (i < 2) ? 1'b1 : seed[8]};
    end
    wr(`LDI_OFF_SSD, '{8'h01});
    chk(active === 1'b1, "run not set");
    wr(`LDI_OFF_DUTY0, '{duty[0], duty[1], duty[2], duty[3]});
    slow = 1'b1;
    wr(`LDI_OFF_CTL0, '{ctl[0], ctl[1], ctl[2], ctl[3]});
    slow = 1'b0;
    verify(1'b0);
    wr(`LDI_OFF_UPD, '{8'h5A});
    verify(1'b0);
    wr(`LDI_OFF_UPD, '{`LDI_UPD_KEY});
    verify(1'b1);
    wr(8'h4B, '{8'hFF, 8'hFF, 8'hFF, 8'hFF});
    verify(1'b1);
    wr(8'hFE, '{8'hFF, 8'hFF, 8'h00});
    chk(active === 1'b0, "pointer did not wrap to shutdown");
    wr(`LDI_OFF_SSD, '{8'h01});
    verify(1'b1);
    wr(`LDI_OFF_GDIS, '{8'h01});
    chk(active === 1'b0 && chan === '0, "global off failed");
    wr(`LDI_OFF_GDIS, '{8'h00});
    chk(active === 1'b1, "global on failed");
    @(negedge core_clk_in);
    pin_n = 1'b0;
    repeat (8) @(negedge core_clk_in);
    chk(active === 1'b0 && chan === '0, "pin shutdown failed");
    pin_n = 1'b1;
    repeat (8) @(negedge core_clk_in);
    chk(active === 1'b1, "pin release failed");
    wr(`LDI_OFF_GDIS, '{8'h01});
    wr(`LDI_OFF_RST, '{8'h00});
    chk(active === 1'b0 && scale === '0, "reset register failed");
    wr(`LDI_OFF_SSD, '{8'h01});
    chk(active === 1'b1, "global disable kept over reset");
    wr(`LDI_OFF_UPD, '{`LDI_UPD_KEY});
    verify(1'b0);
    test_done();
  end
endmodule
